// ### hw/chfo_input_route.v
// Decodes the channel four input selector into one-hot route enables.
// Assumes the analog switch matrix takes exactly one enable high at a time.
`timescale 1ns/1ps
`include "chfo_map.vh"

module chfo_input_route (
    input  wire       clk_i,            // System clock
    input  wire       resetn_i,         // Async reset, active low
    input  wire [1:0] sel_i,            // Input selector code
    output reg        route_pins_o,     // Connect external pin pair
    output reg        route_short_o,    // Short converter inputs
    output reg        route_test_pos_o, // Positive DC test signal
    output reg        route_test_neg_o  // Negative DC test signal
);

    // ======================================================================
    // Registered decode, glitch-free for the switch drivers
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            route_pins_o     <= 1'b1;
            route_short_o    <= 1'b0;
            route_test_pos_o <= 1'b0;
            route_test_neg_o <= 1'b0;
        end else begin
            route_pins_o     <= 1'b0;
            route_short_o    <= 1'b0;
            route_test_pos_o <= 1'b0;
            route_test_neg_o <= 1'b0;
            case (sel_i)
                `CHFO_SEL_PINS:     route_pins_o     <= 1'b1;
                `CHFO_SEL_SHORT:    route_short_o    <= 1'b1;
                `CHFO_SEL_TEST_POS: route_test_pos_o <= 1'b1;
                `CHFO_SEL_TEST_NEG: route_test_neg_o <= 1'b1;
                default:            route_pins_o     <= 1'b1;
            endcase
        end
    end

endmodule

// ### hw/chfo_map.vh
// Overview of operation
// - Input selector resets to external pin pair
// - Code 01b shorts the converter inputs
// - Code 10b feeds positive DC test
// - Code 11b feeds negative DC test
// - Upper offset trim register, index 1Eh, reset 0000h
// - Upper register holds offset bits 23:8
// - Lower offset trim register, index 1Fh, reset 0000h
// - Lower bits 15:8 hold offset bits 7:0
// - Offset word is signed two's complement
// - Lower bits 7:0 read zero, ignore writes
//
// Constants for the channel four input and offset trim register slice.
// Assumes an AXI4-Lite master with 32-bit data and word-aligned accesses.
`ifndef CHFO_MAP_VH
`define CHFO_MAP_VH

// ==========================================================================
// Register indices (byte address is four times the index)
`define CHFO_IDX_W          6
`define CHFO_IDX_STAT       6'h1C
`define CHFO_IDX_CFG        6'h1D
`define CHFO_IDX_OFS_HI     6'h1E
`define CHFO_IDX_OFS_LO     6'h1F

// ==========================================================================
// Input selector codes
`define CHFO_SEL_PINS       2'h0
`define CHFO_SEL_SHORT      2'h1
`define CHFO_SEL_TEST_POS   2'h2
`define CHFO_SEL_TEST_NEG   2'h3

// ==========================================================================
// Field positions
`define CHFO_SEL_LSB        0
`define CHFO_LO_FIELD_LSB   8
`define CHFO_STAT_SIGN_BIT  4

// ==========================================================================
// Reset values
`define CHFO_RST_SEL        2'h0
`define CHFO_RST_OFS_HI     16'h0000
`define CHFO_RST_OFS_LO     8'h00
`define CHFO_LO_RESERVED    8'h00

// ==========================================================================
// Bus responses
`define CHFO_RESP_OKAY      2'h0
`define CHFO_RESP_SLVERR    2'h2

`endif

// ### hw/chfo_offset_pack.v
// Packs the two trim registers into the signed 24-bit offset word.
// Assumes the datapath adds the word as two's complement.
`timescale 1ns/1ps

module chfo_offset_pack (
    input  wire        clk_i,         // System clock
    input  wire        resetn_i,      // Async reset, active low
    input  wire [15:0] upper_i,       // Offset bits 23:8
    input  wire [7:0]  lower_i,       // Offset bits 7:0
    output reg  [23:0] offset_word_o, // Packed offset word
    output reg         offset_neg_o   // Offset is negative
);

    // ======================================================================
    // Register the word so the datapath sees both halves change together
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            offset_word_o <= 24'h000000;
            offset_neg_o  <= 1'b0;
        end else begin
            offset_word_o <= {upper_i, lower_i};
            offset_neg_o  <= upper_i[15];
        end
    end

endmodule

// ### hw/chfo_regs.v
// Channel four input selector and offset trim registers, AXI4-Lite slave.
// Assumes a master that keeps one write and one read outstanding at most.
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "chfo_map.vh"

module chfo_regs #(
    parameter ADDR_W = 8                    // Byte address width
) (
    input  wire              clk_i,              // System clock
    input  wire              resetn_i,           // Async reset, active low
    // Write address channel
    input  wire [ADDR_W-1:0] s_axi_awaddr_i,     // Write byte address
    input  wire [2:0]        s_axi_awprot_i,     // Protection, unused
    input  wire              s_axi_awvalid_i,    // Address valid
    output wire              s_axi_awready_o,    // Address accepted
    // Write data channel
    input  wire [31:0]       s_axi_wdata_i,      // Write data
    input  wire [3:0]        s_axi_wstrb_i,      // Byte enables
    input  wire              s_axi_wvalid_i,     // Data valid
    output wire              s_axi_wready_o,     // Data accepted
    // Write response channel
    output reg  [1:0]        s_axi_bresp_o,      // Write response
    output reg               s_axi_bvalid_o,     // Response valid
    input  wire              s_axi_bready_i,     // Response accepted
    // Read address channel
    input  wire [ADDR_W-1:0] s_axi_araddr_i,     // Read byte address
    input  wire [2:0]        s_axi_arprot_i,     // Protection, unused
    input  wire              s_axi_arvalid_i,    // Address valid
    output wire              s_axi_arready_o,    // Address accepted
    // Read data channel
    output reg  [31:0]       s_axi_rdata_o,      // Read data
    output reg  [1:0]        s_axi_rresp_o,      // Read response
    output reg               s_axi_rvalid_o,     // Data valid
    input  wire              s_axi_rready_i,     // Data accepted
    // Analog routing
    output wire              route_pins_o,       // External pins connected
    output wire              route_short_o,      // Inputs shorted
    output wire              route_test_pos_o,   // Positive DC test
    output wire              route_test_neg_o,   // Negative DC test
    // Offset to datapath
    output wire [23:0]       offset_word_o,      // Signed offset word
    output wire              offset_neg_o        // Offset sign
);

    // ======================================================================
    // Register state
    reg  [1:0]              ch_four_input_select;       // Selector field
    reg  [15:0]             ch_four_offset_upper_bits;  // Offset 23:8
    reg  [7:0]              ch_four_offset_lower_bits;  // Offset 7:0

    // ======================================================================
    // Write channel holding state
    reg                     aw_full;     // Write address captured
    reg                     w_full;      // Write data captured
    reg  [`CHFO_IDX_W-1:0]  aw_idx;      // Captured word index
    reg  [31:0]             w_data;      // Captured write data
    reg  [3:0]              w_strb;      // Captured byte enables

    // ======================================================================
    // Decode helpers
    wire [`CHFO_IDX_W-1:0]  ar_idx;      // Read word index
    wire                    do_write;    // Commit write this edge
    wire                    do_read;     // Accept read this edge
    wire                    w_hit;       // Write index is a writable register
    reg                     r_hit;       // Read index is mapped
    reg  [31:0]             next_rdata;  // Read data mux

    // Status view of the routing and sign
    wire [3:0]              route_vec;   // One-hot route enables
    wire [15:0]             stat_word;   // Status register image

    // ======================================================================
    // Handshake outputs
    // Each address/data channel stalls once it holds an item until the
    // write commits; this caps us at one write in flight.
    assign s_axi_awready_o = !aw_full;
    assign s_axi_wready_o  = !w_full;

    // Read address only taken while no read answer is pending
    assign s_axi_arready_o = !s_axi_rvalid_o;

    // ======================================================================
    // Index extraction; low two address bits ignored (word aligned)
    assign ar_idx = s_axi_araddr_i[`CHFO_IDX_W+1:2];

    // Write commits once address and data are both in and the previous
    // response has been taken, so a response is never overwritten.
    assign do_write = aw_full && w_full && !s_axi_bvalid_o;
    assign do_read  = s_axi_arvalid_i && !s_axi_rvalid_o;

    // Only the selector and the two trim words accept writes
    assign w_hit = (aw_idx == `CHFO_IDX_CFG)    ||
                   (aw_idx == `CHFO_IDX_OFS_HI) ||
                   (aw_idx == `CHFO_IDX_OFS_LO);

    // ======================================================================
    // Capture write address, in any order relative to data
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            aw_full <= 1'b0;
            aw_idx  <= {`CHFO_IDX_W{1'b0}};
        end else if (s_axi_awvalid_i && !aw_full) begin
            // Take the address and hold it
            aw_full <= 1'b1;
            aw_idx  <= s_axi_awaddr_i[`CHFO_IDX_W+1:2];
        end else if (do_write) begin
            // Release for the next write
            aw_full <= 1'b0;
        end
    end

    // ======================================================================
    // Capture write data, in any order relative to address
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            w_full <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid_i && !w_full) begin
            // Take the data beat and hold it
            w_full <= 1'b1;
            w_data <= s_axi_wdata_i;
            w_strb <= s_axi_wstrb_i;
        end else if (do_write) begin
            // Release for the next write
            w_full <= 1'b0;
        end
    end

    // ======================================================================
    // Register writes, byte lanes honoured
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ch_four_input_select      <= `CHFO_RST_SEL;
            ch_four_offset_upper_bits <= `CHFO_RST_OFS_HI;
            ch_four_offset_lower_bits <= `CHFO_RST_OFS_LO;
        end else if (do_write) begin
            case (aw_idx)
                `CHFO_IDX_CFG: begin
                    // Selector lives in lane 0
                    if (w_strb[0]) begin
                        ch_four_input_select <=
                            w_data[`CHFO_SEL_LSB+1:`CHFO_SEL_LSB];
                    end
                end
                `CHFO_IDX_OFS_HI: begin
                    // Full sixteen bits, two lanes
                    if (w_strb[0]) begin
                        ch_four_offset_upper_bits[7:0] <= w_data[7:0];
                    end
                    if (w_strb[1]) begin
                        ch_four_offset_upper_bits[15:8] <= w_data[15:8];
                    end
                end
                `CHFO_IDX_OFS_LO: begin
                    // Lane 0 is reserved; its write data are dropped
                    if (w_strb[1]) begin
                        ch_four_offset_lower_bits <=
                            w_data[`CHFO_LO_FIELD_LSB+7:`CHFO_LO_FIELD_LSB];
                    end
                end
                default: begin
                    // Unmapped or read-only: nothing stored
                end
            endcase
        end
    end

    // ======================================================================
    // Write response
    // OKAY for writes to the selector and trim words, SLVERR for anything else (status included)
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= `CHFO_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= w_hit ? `CHFO_RESP_OKAY : `CHFO_RESP_SLVERR;
        end else if (s_axi_bready_i) begin
            // Response taken by the master
            s_axi_bvalid_o <= 1'b0;
        end
    end

    // ======================================================================
    // Status image: route enables and offset sign
    // Reads the registered outputs, so it lags a selector write by one
    // cycle; software sees what the switches really do.
    assign route_vec = {route_test_neg_o, route_test_pos_o,
                        route_short_o, route_pins_o};
    assign stat_word = {11'h000, offset_neg_o, route_vec};

    // ======================================================================
    // Read data mux
    always @* begin
        next_rdata = 32'h00000000;
        r_hit      = 1'b1;
        case (ar_idx)
            `CHFO_IDX_STAT: begin
                // Live routing and sign
                next_rdata = {16'h0000, stat_word};
            end
            `CHFO_IDX_CFG: begin
                // Selector in its field, rest zero
                next_rdata = {30'h00000000, ch_four_input_select};
            end
            `CHFO_IDX_OFS_HI: begin
                // Offset bits 23:8
                next_rdata = {16'h0000, ch_four_offset_upper_bits};
            end
            `CHFO_IDX_OFS_LO: begin
                // Offset bits 7:0 over a reserved zero byte
                next_rdata = {16'h0000, ch_four_offset_lower_bits,
                              `CHFO_LO_RESERVED};
            end
            default: begin
                // Unmapped: zero data, error response
                r_hit = 1'b0;
            end
        endcase
    end

    // ======================================================================
    // Read response, one cycle after the address is taken
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o  <= 32'h00000000;
            s_axi_rresp_o  <= `CHFO_RESP_OKAY;
        end else if (do_read) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o  <= next_rdata;
            s_axi_rresp_o  <= r_hit ? `CHFO_RESP_OKAY : `CHFO_RESP_SLVERR;
        end else if (s_axi_rready_i) begin
            // Data taken by the master
            s_axi_rvalid_o <= 1'b0;
        end
    end

    // ======================================================================
    // Input routing decode
    chfo_input_route u_route (
        .clk_i            (clk_i),
        .resetn_i         (resetn_i),
        .sel_i            (ch_four_input_select),
        .route_pins_o     (route_pins_o),
        .route_short_o    (route_short_o),
        .route_test_pos_o (route_test_pos_o),
        .route_test_neg_o (route_test_neg_o)
    );

    // ======================================================================
    // Offset word packing
    chfo_offset_pack u_pack (
        .clk_i         (clk_i),
        .resetn_i      (resetn_i),
        .upper_i       (ch_four_offset_upper_bits),
        .lower_i       (ch_four_offset_lower_bits),
        .offset_word_o (offset_word_o),
        .offset_neg_o  (offset_neg_o)
    );

endmodule

// ### sim/chfo_regs_sva.sv
// Checker for the channel four input selector and offset trim slice.
// Assumes it is bound to chfo_regs and sees only that module's ports.
`timescale 1ns/1ps
`include "chfo_map.vh"

module chfo_regs_sva #(
    parameter ADDR_W = 8                  // Byte address width
) (
    input wire              clk_i,            // System clock
    input wire              resetn_i,         // Async reset, active low
    input wire [ADDR_W-1:0] s_axi_awaddr_i,   // Write address
    input wire              s_axi_awvalid_i,  // Write address valid
    input wire              s_axi_awready_o,  // Write address ready
    input wire [31:0]       s_axi_wdata_i,    // Write data
    input wire [3:0]        s_axi_wstrb_i,    // Byte enables
    input wire              s_axi_wvalid_i,   // Write data valid
    input wire              s_axi_wready_o,   // Write data ready
    input wire              s_axi_bvalid_o,   // Write response valid
    input wire [ADDR_W-1:0] s_axi_araddr_i,   // Read address
    input wire              s_axi_arvalid_i,  // Read address valid
    input wire              s_axi_arready_o,  // Read address ready
    input wire [31:0]       s_axi_rdata_o,    // Read data
    input wire              s_axi_rvalid_o,   // Read data valid
    input wire              route_pins_o,     // Pins route
    input wire              route_short_o,    // Short route
    input wire              route_test_pos_o, // Positive test route
    input wire              route_test_neg_o, // Negative test route
    input wire [23:0]       offset_word_o,    // Packed offset
    input wire              offset_neg_o      // Offset sign
);
    // ======================================================================
    // Capture of the last accepted addresses and data
    reg  [5:0]  aw_idx;  // Index of last write address
    reg  [5:0]  ar_idx;  // Index of last read address
    reg  [31:0] w_data;  // Last write data
    reg  [3:0]  w_strb;  // Last byte enables
    wire [3:0]  route = {route_test_neg_o, route_test_pos_o, route_short_o, route_pins_o};

    // Address and data may be taken on different edges, so each is kept apart
    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            aw_idx <= 6'h00;
            ar_idx <= 6'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) aw_idx <= s_axi_awaddr_i[7:2];
            if (s_axi_arvalid_i && s_axi_arready_o) ar_idx <= s_axi_araddr_i[7:2];
            if (s_axi_wvalid_i && s_axi_wready_o) w_data <= s_axi_wdata_i;
            if (s_axi_wvalid_i && s_axi_wready_o) w_strb <= s_axi_wstrb_i;
        end
    end

    // ======================================================================
    // Properties
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    // Write response just raised for a given register
    sequence wr_done(idx);
        $rose(s_axi_bvalid_o) && aw_idx == idx;
    endsequence

    route_onehot_a: assert property ($onehot(route))
        else $error("route enables not one-hot");
    reset_route_a: assert property ($rose(resetn_i) |-> route_pins_o)
        else $error("pins route not selected after reset");
    sel_route_a: assert property (wr_done(`CHFO_IDX_CFG) ##0 w_strb[0] |=>
        route == (4'h1 << w_data[1:0])) else $error("route differs from selector code");
    hi_word_a: assert property (wr_done(`CHFO_IDX_OFS_HI) ##0 w_strb[1:0] == 2'h3 |=>
        offset_word_o[23:8] == w_data[15:0]) else $error("upper offset bits wrong");
    lo_word_a: assert property (wr_done(`CHFO_IDX_OFS_LO) ##0 w_strb[1] |=>
        offset_word_o[7:0] == w_data[15:8]) else $error("lower offset bits wrong");
    sign_bit_a: assert property (offset_neg_o == offset_word_o[23])
        else $error("offset sign differs from top bit");
    lo_reserved_a: assert property ($rose(s_axi_rvalid_o) &&
        ar_idx == `CHFO_IDX_OFS_LO |-> s_axi_rdata_o[7:0] == 8'h00)
        else $error("reserved lower bits read nonzero");
    hi_read_a: assert property ($rose(s_axi_rvalid_o) && ar_idx == `CHFO_IDX_OFS_HI |->
        s_axi_rdata_o[15:0] == offset_word_o[23:8]) else $error("upper register read wrong");
    read_latency_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("read data late");
endmodule

bind chfo_regs chfo_regs_sva #(.ADDR_W(ADDR_W)) u_chfo_regs_sva (.*);

// ### sim/testbench.sv
// Self-checking bench for the channel four register slice.
// Assumes chfo_regs as the AXI4-Lite slave, driven directly by the bench.
`timescale 1ns/1ps
`include "chfo_map.vh"

module testbench;
    // ======================================================================
    // Signals
    reg         clk_i = 1'b0;             // 50 MHz clock
    reg         resetn_i = 1'b0;          // Reset, active low
    reg  [7:0]  s_axi_awaddr_i = 8'h00;   // Write address
    reg  [2:0]  s_axi_awprot_i = 3'h0;    // Unused protection
    reg         s_axi_awvalid_i = 1'b0;   // Write address valid
    wire        s_axi_awready_o;          // Write address ready
    reg  [31:0] s_axi_wdata_i = 32'h0;    // Write data
    reg  [3:0]  s_axi_wstrb_i = 4'h0;     // Byte enables
    reg         s_axi_wvalid_i = 1'b0;    // Write data valid
    wire        s_axi_wready_o;           // Write data ready
    wire [1:0]  s_axi_bresp_o;            // Write response
    wire        s_axi_bvalid_o;           // Write response valid
    reg         s_axi_bready_i = 1'b0;    // Write response ready
    reg  [7:0]  s_axi_araddr_i = 8'h00;   // Read address
    reg  [2:0]  s_axi_arprot_i = 3'h0;    // Unused protection
    reg         s_axi_arvalid_i = 1'b0;   // Read address valid
    wire        s_axi_arready_o;          // Read address ready
    wire [31:0] s_axi_rdata_o;            // Read data
    wire [1:0]  s_axi_rresp_o;            // Read response
    wire        s_axi_rvalid_o;           // Read data valid
    reg         s_axi_rready_i = 1'b0;    // Read data ready
    wire        route_pins_o, route_short_o, route_test_pos_o, route_test_neg_o;
    wire [23:0] offset_word_o;            // Packed offset
    wire        offset_neg_o;             // Offset sign
    wire [3:0]  route = {route_test_neg_o, route_test_pos_o, route_short_o, route_pins_o};
    int         failures = 0;             // Mismatch count
    int         n_checks = 0;             // Comparison count
    localparam [5:0] STAT = `CHFO_IDX_STAT, CFG = `CHFO_IDX_CFG;
    localparam [5:0] HI = `CHFO_IDX_OFS_HI, LO = `CHFO_IDX_OFS_LO;
    localparam [1:0] OK = `CHFO_RESP_OKAY, ERR = `CHFO_RESP_SLVERR;

    chfo_regs u_chfo_regs (.*);

    // Free-running clock
    always #10 clk_i = ~clk_i;

    // ======================================================================
    // Tasks
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask

    // Offers address and data together; releases each when taken
    task automatic bus_write(input logic [5:0] idx, input logic [31:0] data,
                             input logic [3:0] strb, input logic [1:0] resp);
        s_axi_awaddr_i <= {idx, 2'h0};
        s_axi_awvalid_i <= 1'b1;
        s_axi_wdata_i <= data;
        s_axi_wstrb_i <= strb;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        do begin
            @(posedge clk_i);
            if (s_axi_awvalid_i && s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wvalid_i && s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
            if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bready_i <= 1'b0;
                check("bresp", {30'h0, resp}, {30'h0, s_axi_bresp_o});
            end
        end while (s_axi_awvalid_i || s_axi_wvalid_i || s_axi_bready_i);
    endtask

    task automatic bus_read(input logic [5:0] idx, input logic [31:0] data,
                            input logic [1:0] resp);
        s_axi_araddr_i <= {idx, 2'h0};
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        do begin
            @(posedge clk_i);
            if (s_axi_arvalid_i && s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
            if (s_axi_rvalid_o && s_axi_rready_i) begin
                s_axi_rready_i <= 1'b0;
                check("rdata", data, s_axi_rdata_o);
                check("rresp", {30'h0, resp}, {30'h0, s_axi_rresp_o});
            end
        end while (s_axi_arvalid_i || s_axi_rready_i);
    endtask

    task automatic conclude();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Watchdog, far beyond the hundred or so cycles the tests need
    initial begin
        #100000;
        failures++;
        conclude();
    end

    // ======================================================================
    // Test sequence
    initial begin
        repeat (10) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        check("route", 32'h1, {28'h0, route});
        bus_read(HI, 32'h0, OK);
        bus_read(LO, 32'h0, OK);
        bus_read(CFG, 32'h0, OK);
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            bus_write(CFG, 32'(i), 4'h1, OK);
            check("route", {28'h0, 4'h1 << i}, {28'h0, route});
            bus_read(STAT, {28'h0, 4'h1 << i}, OK);
        end
        bus_write(CFG, 32'h0, 4'h1, OK);
        $display("test selector codes done");
        bus_write(HI, 32'h0000_8001, 4'h3, OK);
        bus_write(LO, 32'h0000_FFFF, 4'h3, OK);
        bus_read(LO, 32'h0000_FF00, OK);
        bus_read(HI, 32'h0000_8001, OK);
        check("offset", 32'h0080_01FF, {8'h0, offset_word_o});
        check("sign", 32'h1, {31'h0, offset_neg_o});
        bus_read(STAT, 32'h0000_0011, OK);
        bus_write(LO, 32'h0000_00AA, 4'h1, OK);
        bus_read(LO, 32'h0000_FF00, OK);
        bus_write(HI, 32'h0000_7FFE, 4'h3, OK);
        bus_write(LO, 32'h0000_1200, 4'h3, OK);
        check("offset", 32'h007F_FE12, {8'h0, offset_word_o});
        check("sign", 32'h0, {31'h0, offset_neg_o});
        $display("test offset trim done");
        bus_write(6'h3F, 32'h0000_1234, 4'hF, ERR);
        bus_read(6'h3F, 32'h0, ERR);
        bus_write(STAT, 32'h0000_000F, 4'hF, ERR);
        bus_read(STAT, 32'h0000_0001, OK);
        $display("test refused accesses done");
        // Leave a non-default selector so the reset value is really tested
        bus_write(CFG, 32'h0000_0003, 4'h1, OK);
        resetn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        bus_read(HI, 32'h0, OK);
        bus_read(LO, 32'h0, OK);
        bus_read(CFG, 32'h0, OK);
        check("route", 32'h1, {28'h0, route});
        $display("test second reset done");
        conclude();
    end
endmodule
